//--- bench/converter_param_alarm_unit_tb.sv
// Purpose: self-checking bench for the converter parameter and alarm block
// Assumes: shortened limits: undervoltage 20, filters 3/6/9, write count 50
// Notes:   the store is formatted only where boot is given a 1
module converter_param_alarm_unit_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, fmt = 1'b0, cyc = 1'b0, we = 1'b0, key = 1'b0;
  logic        ack, rdy, trb, con, dal, dwr, irq, pok;
  logic [7:0]  adr = 8'h0, code, rsel;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic [2:0]  item;
  logic [3:0]  fin, ext;
  logic [3:0]  sel = 4'h3;
  logic [15:0] trouble_output;
  logic [4:0]  warn;
  int          err_total, checks, ncyc;
  int          idx[5] = '{0, 1, 7, 8, 11};
  logic [15:0] dflt[5] = '{16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0002};
  cpa_unit #(.UV_LIMIT(20), .FILT1_LIMIT(3), .FILT2_LIMIT(6), .FILT3_LIMIT(9), .WR_LIMIT(50)) cpa_unit_inst (
    .CLK_I(clk), .RESET_I(rst), .ADR_I(adr), .DAT_I(wdat), .DAT_O(rdat), .WE_I(we), .SEL_I(sel),
    .CYC_I(cyc), .STB_I(cyc), .ACK_O(ack), .NV_FORMAT_I(fmt), .CTRL_POWER_OK_I(pok),
    .ALARM_DETECT_I(trouble_output), .WARN_DETECT_I(warn), .EXT_IN_I(ext), .RESET_KEY_I(key), .FILT_IN_O(fin),
    .READY_O(rdy), .TROUBLE_OUTPUT_O(trb), .CONTACTOR_DRIVE_O(con), .REGEN_SELECT_O(rsel),
    .DISP_ALARM_O(dal), .DISP_WARN_O(dwr), .DISP_CODE_O(code), .DISP_ITEM_O(item), .IRQ_O(irq));
  cpa_plant cpa_plant_inst (.clk_i(clk), .alm_o(trouble_output), .warn_o(warn), .pwr_ok_o(pok), .ext_o(ext));
  initial begin
    forever #25 clk = ~clk;
  end
  // a hung handshake must still reach the verdict
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == 4000) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  // classic cycle: hold until ack, then one idle cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat;
    cyc <= 1'b0;
    @(posedge clk);
    if (n == 20) err_total++;
  endtask
  task automatic boot(input logic f);
    rst <= 1'b1;
    fmt <= f;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    fmt <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    boot(1'b1);
    chk(rdy, 1'b1);
    foreach (idx[i]) begin
      wb(1'b0, 8'(idx[i] * 4), 32'h0);
      chk(rd[15:0], dflt[i]);
    end
    chk({con, item}, 4'h8);
    wb(1'b1, 8'h08, 32'hFFFF);
    wb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, 8'hFC, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h88, 32'h1);
    $display("test defaults done");
    cpa_plant_inst.pulse_alm(6);
    settle();
    chk({trb, irq, code}, {2'b01, 8'h33});
    wb(1'b1, 8'h8C, 32'h1);
    wb(1'b1, 8'h80, 32'h1);
    settle();
    chk({trb, irq}, 2'b10);
    cpa_plant_inst.pulse_alm(13);
    settle();
    key <= 1'b1;
    @(posedge clk);
    key <= 1'b0;
    settle();
    chk(dal, 1'b0);
    cpa_plant_inst.set_level(1'b1, 0, 1'b1);
    settle();
    chk({dwr, trb, code}, {2'b11, 8'h91});
    cpa_plant_inst.set_level(1'b1, 0, 1'b0);
    cpa_plant_inst.set_level(1'b0, 1, 1'b1);
    repeat (4) @(posedge clk);
    chk(fin[1], 1'b0);
    repeat (6) @(posedge clk);
    chk(fin[1], 1'b1);
    cpa_plant_inst.dip(22);
    settle();
    chk(code, 8'h10);
    wb(1'b1, 8'h80, 32'h1);
    wb(1'b0, 8'h68, 32'h0);
    chk(rd[7:0], 8'h33);
    chk(trb, 1'b1);
    cpa_plant_inst.pulse_alm(5);
    cpa_plant_inst.set_level(1'b0, 0, 1'b1);
    repeat (3) @(posedge clk);
    chk(dal, 1'b1);
    repeat (7) @(posedge clk);
    chk({dal, trb}, 2'b01);
    cpa_plant_inst.set_level(1'b0, 0, 1'b0);
    $display("test alarms done");
    wb(1'b1, 8'h04, 32'h0);
    wb(1'b1, 8'h1C, 32'h4);
    wb(1'b1, 8'h20, 32'h1);
    sel <= 4'h1;
    wb(1'b1, 8'h2C, 32'h0300);
    sel <= 4'h3;
    wb(1'b0, 8'h2C, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h00, 32'h5);
    chk(con, 1'b1);
    boot(1'b0);
    chk({con, item, rsel}, {1'b0, 3'h4, 8'h05});
    chk({dal, code}, {1'b1, 8'h37});
    cpa_plant_inst.set_level(1'b0, 2, 1'b1);
    repeat (2) @(posedge clk);
    chk(fin[2], 1'b1);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h64, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, 8'h84, 32'h0);
    chk(rd, 32'hD);
    wb(1'b1, 8'h80, 32'h1);
    settle();
    chk(dal, 1'b1);
    wb(1'b1, 8'h00, 32'h0);
    boot(1'b0);
    chk({dal, trb}, 2'b01);
    $display("test settings done");
    boot(1'b1);
    repeat (50) wb(1'b1, 8'h1C, 32'h0);
    chk(dal, 1'b0);
    wb(1'b1, 8'h1C, 32'h0);
    settle();
    chk({dal, code}, {1'b1, 8'h15});
    $display("test write count done");
    print_verdict();
  end
endmodule // converter_param_alarm_unit_tb

//--- bench/cpa_plant.sv
// Purpose: detector and field I/O model beside the converter block
// Assumes: tasks are called just after a rising clock edge
// Notes:   every level holds until a task changes it
module cpa_plant (
  input  wire logic        clk_i,
  output logic      [15:0] alm_o    = 16'h0,
  output logic      [4:0]  warn_o   = 5'h0,
  output logic             pwr_ok_o = 1'b1,
  output logic      [3:0]  ext_o    = 4'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic pulse_alm(input int i);
    alm_o[i] <= 1'b1;
    @(posedge clk_i);
    alm_o[i] <= 1'b0;
  endtask
  task automatic set_level(input logic w, input int i, input logic v);
    if (w) warn_o[i] <= v;
    else ext_o[i] <= v;
  endtask
  task automatic dip(input int n);
    pwr_ok_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    pwr_ok_o <= 1'b1;
  endtask
endmodule // cpa_plant

//--- rtl/cpa_pkg.sv
// Purpose: constants for the converter parameter store and alarm manager
// Assumes: 20 MHz clock, classic Wishbone slave with 32-bit data
// Notes:   register offsets are byte addresses, one aligned word each
package cpa_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ         = 20000000;
  localparam int UV_TIME_MS     = 60;
  localparam int UV_CYCLES      = UV_TIME_MS * (CLK_HZ / 1000);
  localparam int FILT1_TIME_NS  = 1777700;
  localparam int FILT2_TIME_NS  = 3555000;
  localparam int FILT3_TIME_NS  = 5333000;
  localparam int FILT1_CYCLES   = (FILT1_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int FILT2_CYCLES   = (FILT2_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int FILT3_CYCLES   = (FILT3_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int NV_WRITE_LIMIT = 100000;

  // ----------------------------------------------------------------
  // parameter store
  // ----------------------------------------------------------------
  localparam int NUM_PARAM  = 18;
  localparam int IDX_REGEN  = 0;
  localparam int IDX_MCC    = 1;
  localparam int IDX_DISP   = 7;
  localparam int IDX_ERASE  = 8;
  localparam int IDX_FILT   = 11;
  localparam logic [17:0] PARAM_WRITABLE = 18'h00983;
  localparam logic [15:0] PARAM_FACTORY [NUM_PARAM] = '{
    16'h0000, 16'h0001, 16'h0001, 16'h0000, 16'h0064, 16'h0000, 16'h0064, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_PARAM0   = 8'h00;
  localparam logic [7:0] ADR_PARAM_END = 8'h44;
  localparam logic [7:0] ADR_ALM_STAT = 8'h50;
  localparam logic [7:0] ADR_WARN     = 8'h54;
  localparam logic [7:0] ADR_ACTIVE   = 8'h58;
  localparam logic [7:0] ADR_WR_COUNT = 8'h5C;
  localparam logic [7:0] ADR_HIST0    = 8'h60;
  localparam logic [7:0] ADR_HIST_END = 8'h78;
  localparam logic [7:0] ADR_CMD      = 8'h80;
  localparam logic [7:0] ADR_IRQ_STAT = 8'h84;
  localparam logic [7:0] ADR_IRQ_EN   = 8'h88;
  localparam logic [7:0] ADR_IRQ_CLR  = 8'h8C;
  localparam int CMD_ERR_RESET = 0;
  localparam int IRQ_ALARM     = 0;
  localparam int IRQ_WARN      = 1;
  localparam int IRQ_READY     = 2;
  localparam int IRQ_ERASED    = 3;
  localparam int NUM_IRQ       = 4;

  // ----------------------------------------------------------------
  // alarms and warnings
  // ----------------------------------------------------------------
  localparam int NUM_ALM  = 16;
  localparam int NUM_WARN = 5;
  localparam int HIST_LEN = 7;
  localparam int ALM_UV   = 0;
  localparam int ALM_NVM  = 2;
  localparam int ALM_PRM  = 7;
  // bit order: 10 12 15 17 19 30 33 37 38 39 3A 45 47 50 51 watchdog
  localparam logic [7:0] ALM_CODE [NUM_ALM] = '{
    8'h10, 8'h12, 8'h15, 8'h17, 8'h19, 8'h30, 8'h33, 8'h37,
    8'h38, 8'h39, 8'h3A, 8'h45, 8'h47, 8'h50, 8'h51, 8'h88};
  localparam logic [15:0] ALM_RESETTABLE = 16'h6861;
  // overheat, regen load, overload, forced stop, fan slow
  localparam logic [7:0] WARN_CODE [NUM_WARN] = '{8'h91, 8'hE0, 8'hE1, 8'hE6, 8'hE8};
  localparam logic [7:0] DISP_ITEM_MAX = 8'h04;

  typedef enum logic [1:0] {ST_LOAD, ST_ERASE, ST_READY} cpa_state_type;
endpackage : cpa_pkg

//--- rtl/cpa_unit.sv
// Purpose: parameter store and alarm manager of a drive converter unit
// Assumes: RESET_I stands for a power cycle or controller reset; NV_FORMAT_I stands for factory programming
// Notes:   the nonvolatile store, write count and history ignore RESET_I on purpose

// What this block does
// RL1 - regen option field picks none (00) or an external resistor set; reset 0000h
// RL2 - an invalid regen option raises parameter error A.37
// RL3 - contactor drive output on when selection is 1, off at 0; reset 0001h
// RL4 - display choice 0..4 picks the status item shown after power-on
// RL5 - a valid history erase setting erases history at next power-on only
// RL6 - after erasing, the erase setting returns to 0 by itself
// RL7 - external inputs debounced by none, 1.7777, 3.555 or 5.333 ms; default 2
// RL8 - host never changes maker settings; they keep factory values
// RL9 - power-on settings take effect only after power cycle or controller reset
// RL10 - alarms stay latched; a power cycle clears every alarm
// RL11 - error reset clears A.10, A.30, A.33, A.45, A.50, A.51
// RL12 - memory, board, parameter, contactor, phase, fan, watchdog alarms ignore error reset
// RL13 - any alarm drops the trouble output and shows the alarm number
// RL14 - control power lost over 60 ms raises undervoltage A.10
// RL15 - nonvolatile writes counted; above 100,000 raises memory alarm A.15
// RL16 - self-check codes A.12 RAM, A.15 parameter memory, A.17 board, A.19 program memory
// RL17 - warnings A.91, A.E0, A.E1, A.E6, A.E8 reported without tripping
// RL18 - history keeps current alarm plus six past alarms, newest first
// RL19 - stored values load into active settings during init before ready
module cpa_unit #(
  parameter int NUM_IN      = 4,
  parameter int UV_LIMIT    = cpa_pkg::UV_CYCLES,
  parameter int FILT1_LIMIT = cpa_pkg::FILT1_CYCLES,
  parameter int FILT2_LIMIT = cpa_pkg::FILT2_CYCLES,
  parameter int FILT3_LIMIT = cpa_pkg::FILT3_CYCLES,
  parameter int WR_LIMIT    = cpa_pkg::NV_WRITE_LIMIT
) (
  input  wire logic                         CLK_I,
  input  wire logic                         RESET_I,
  input  wire logic [7:0]                   ADR_I,
  input  wire logic [31:0]                  DAT_I,
  output logic      [31:0]                  DAT_O,
  input  wire logic                         WE_I,
  input  wire logic [3:0]                   SEL_I,
  input  wire logic                         CYC_I,
  input  wire logic                         STB_I,
  output logic                              ACK_O,
  input  wire logic                         NV_FORMAT_I,
  input  wire logic                         CTRL_POWER_OK_I,
  input  wire logic [cpa_pkg::NUM_ALM-1:0]  ALARM_DETECT_I,
  input  wire logic [cpa_pkg::NUM_WARN-1:0] WARN_DETECT_I,
  input  wire logic [NUM_IN-1:0]            EXT_IN_I,
  input  wire logic                         RESET_KEY_I,
  output logic [NUM_IN-1:0]                 FILT_IN_O,
  output logic                              READY_O,
  output logic                              TROUBLE_OUTPUT_O,
  output logic                              CONTACTOR_DRIVE_O,
  output logic [7:0]                        REGEN_SELECT_O,
  output logic                              DISP_ALARM_O,
  output logic                              DISP_WARN_O,
  output logic [7:0]                        DISP_CODE_O,
  output logic [2:0]                        DISP_ITEM_O,
  output logic                              IRQ_O
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cpa_pkg::cpa_state_type state;
  logic [15:0] nv_param [cpa_pkg::NUM_PARAM];
  logic [7:0]  hist [cpa_pkg::HIST_LEN];
  logic [31:0] nv_wr_count;
  logic [15:0] act_regen;
  logic [15:0] act_mcc;
  logic [15:0] act_disp;
  logic [15:0] act_filt;
  logic [15:0] alm_lat;
  logic [15:0] alm_ev;
  logic [15:0] next_alm_lat;
  logic [4:0]  warn_q;
  logic [31:0] uv_cnt;
  logic        uv_ev;
  logic        ready;
  logic        regen_ok;
  logic        new_alarm;
  logic        err_reset;
  logic        rst_in_q;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_en;
  logic [3:0]  irq_ev;
  logic        wb_req;
  logic        wb_wr;
  logic [4:0]  p_idx;
  logic        p_hit;
  logic [2:0]  h_idx;
  logic        h_hit;
  logic [31:0] filt_limit;
  logic [31:0] rd_data;

  assign ready  = (state == cpa_pkg::ST_READY);
  assign wb_req = CYC_I & STB_I & ~ACK_O;
  assign wb_wr  = wb_req & WE_I;
  assign p_idx  = ADR_I[6:2];
  assign p_hit  = (ADR_I <= cpa_pkg::ADR_PARAM_END) && (ADR_I[1:0] == 2'b00);
  assign h_idx  = 3'((ADR_I - cpa_pkg::ADR_HIST0) >> 2);
  assign h_hit  = (ADR_I >= cpa_pkg::ADR_HIST0) && (ADR_I <= cpa_pkg::ADR_HIST_END) && (ADR_I[1:0] == 2'b00);

  function automatic logic [7:0] first_code(input logic [15:0] ev);
    logic [7:0] c;
    c = 8'h00;
    for (int i = cpa_pkg::NUM_ALM - 1; i >= 0; i--) begin
      if (ev[i]) begin
        c = cpa_pkg::ALM_CODE[i];
      end
    end
    return c;
  endfunction

  // ----------------------------------------------------------------
  // power-on sequence
  // ----------------------------------------------------------------
  // RL19 load then ready
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      state <= cpa_pkg::ST_LOAD;
    end else begin
      unique case (state)
        cpa_pkg::ST_LOAD: begin
          // RL5 erase at power-on
          state <= (nv_param[cpa_pkg::IDX_ERASE][3:0] == 4'h1) ? cpa_pkg::ST_ERASE : cpa_pkg::ST_READY;
        end
        cpa_pkg::ST_ERASE: begin
          state <= cpa_pkg::ST_READY;
        end
        cpa_pkg::ST_READY: begin
          state <= cpa_pkg::ST_READY;
        end
      endcase
    end
  end

  // RL9 active copy only at init
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      act_regen <= cpa_pkg::PARAM_FACTORY[cpa_pkg::IDX_REGEN];
      act_mcc   <= cpa_pkg::PARAM_FACTORY[cpa_pkg::IDX_MCC];
      act_disp  <= cpa_pkg::PARAM_FACTORY[cpa_pkg::IDX_DISP];
      act_filt  <= cpa_pkg::PARAM_FACTORY[cpa_pkg::IDX_FILT];
    end else if (state == cpa_pkg::ST_LOAD) begin
      act_regen <= nv_param[cpa_pkg::IDX_REGEN];
      act_mcc   <= nv_param[cpa_pkg::IDX_MCC];
      act_disp  <= nv_param[cpa_pkg::IDX_DISP];
      act_filt  <= nv_param[cpa_pkg::IDX_FILT];
    end
  end

  // ----------------------------------------------------------------
  // nonvolatile store and write counter
  // ----------------------------------------------------------------
  // maker settings are not host-writable, so a stray write cannot corrupt them
  always_ff @(posedge CLK_I) begin
    if (NV_FORMAT_I) begin
      for (int i = 0; i < cpa_pkg::NUM_PARAM; i++) begin
        nv_param[i] <= cpa_pkg::PARAM_FACTORY[i];
      end
    end else if (state == cpa_pkg::ST_ERASE) begin
      // RL6 erase setting self-clears
      nv_param[cpa_pkg::IDX_ERASE] <= 16'h0000;
    end else if (wb_wr && p_hit && cpa_pkg::PARAM_WRITABLE[p_idx]) begin
      if (SEL_I[0]) begin
        nv_param[p_idx][7:0] <= DAT_I[7:0];
      end
      if (SEL_I[1]) begin
        nv_param[p_idx][15:8] <= DAT_I[15:8];
      end
    end
  end

  // RL15 count nonvolatile writes
  always_ff @(posedge CLK_I) begin
    if (NV_FORMAT_I) begin
      nv_wr_count <= 32'h00000000;
    end else if ((state == cpa_pkg::ST_ERASE) ||
                 (wb_wr && p_hit && cpa_pkg::PARAM_WRITABLE[p_idx] && (SEL_I[1:0] != 2'b00))) begin
      if (nv_wr_count != 32'hFFFFFFFF) begin
        nv_wr_count <= nv_wr_count + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // input filter
  // ----------------------------------------------------------------
  // RL7 filter delay select
  always_comb begin
    unique case (act_filt[3:0])
      4'h0:    filt_limit = 32'h00000000;
      4'h1:    filt_limit = 32'(FILT1_LIMIT);
      4'h2:    filt_limit = 32'(FILT2_LIMIT);
      default: filt_limit = 32'(FILT3_LIMIT);
    endcase
  end

  for (genvar g = 0; g < NUM_IN; g++) begin : g_filt
    logic [31:0] cnt;
    // RL7 stable for the delay
    always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
        cnt          <= 32'h00000000;
        FILT_IN_O[g] <= 1'b0;
      end else if (EXT_IN_I[g] == FILT_IN_O[g]) begin
        cnt <= 32'h00000000;
      end else if (cnt >= filt_limit) begin
        cnt          <= 32'h00000000;
        FILT_IN_O[g] <= EXT_IN_I[g];
      end else begin
        cnt <= cnt + 32'h00000001;
      end
    end
  end

  // ----------------------------------------------------------------
  // alarm detection and latch
  // ----------------------------------------------------------------
  // RL14 undervoltage timer
  always_ff @(posedge CLK_I) begin
    if (RESET_I || CTRL_POWER_OK_I) begin
      uv_cnt <= 32'h00000000;
    end else if (uv_cnt <= 32'(UV_LIMIT)) begin
      uv_cnt <= uv_cnt + 32'h00000001;
    end
  end
  assign uv_ev = (uv_cnt > 32'(UV_LIMIT));

  // RL1 valid regen codes
  assign regen_ok = (act_regen[15:8] == 8'h00) && ((act_regen[7:0] == 8'h00) || (act_regen[7:0] == 8'h01) ||
                    (act_regen[7:0] == 8'h02) || (act_regen[7:0] == 8'h11) || (act_regen[7:0] == 8'h12));

  // RL16 self-check inputs map to own codes
  always_comb begin
    alm_ev = ALARM_DETECT_I;
    alm_ev[cpa_pkg::ALM_UV]  = ALARM_DETECT_I[cpa_pkg::ALM_UV] | uv_ev;
    // RL15 write limit
    alm_ev[cpa_pkg::ALM_NVM] = ALARM_DETECT_I[cpa_pkg::ALM_NVM] | (nv_wr_count > 32'(WR_LIMIT));
    // RL2 parameter error
    alm_ev[cpa_pkg::ALM_PRM] = ALARM_DETECT_I[cpa_pkg::ALM_PRM] | ~regen_ok;
    if (!ready) begin
      alm_ev = 16'h0000;
    end
  end

  // error reset is a rising edge of filtered input 0, the key while held high, or a write of the command bit
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      rst_in_q <= 1'b0;
    end else begin
      rst_in_q <= FILT_IN_O[0];
    end
  end
  assign err_reset = (FILT_IN_O[0] & ~rst_in_q) | RESET_KEY_I |
                     (wb_wr && (ADR_I == cpa_pkg::ADR_CMD) && SEL_I[0] && DAT_I[cpa_pkg::CMD_ERR_RESET]);

  // RL11 RL12 only resettable bits clear; a new event wins
  assign next_alm_lat = (alm_lat & ~({16{err_reset}} & cpa_pkg::ALM_RESETTABLE)) | alm_ev;
  assign new_alarm    = ready && (alm_ev != 16'h0000) && (alm_lat == 16'h0000);

  // RL10 latched until power cycle
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      alm_lat <= 16'h0000;
    end else begin
      alm_lat <= next_alm_lat;
    end
  end

  // RL18 newest first, seven deep
  always_ff @(posedge CLK_I) begin
    if (NV_FORMAT_I || state == cpa_pkg::ST_ERASE) begin
      for (int i = 0; i < cpa_pkg::HIST_LEN; i++) begin
        hist[i] <= 8'h00;
      end
    end else if (new_alarm) begin
      hist[0] <= first_code(alm_ev);
      for (int i = 1; i < cpa_pkg::HIST_LEN; i++) begin
        hist[i] <= hist[i-1];
      end
    end
  end

  // RL17 warnings never latch
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      warn_q <= 5'h00;
    end else begin
      warn_q <= ready ? WARN_DETECT_I : 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      READY_O           <= 1'b0;
      TROUBLE_OUTPUT_O  <= 1'b0;
      CONTACTOR_DRIVE_O <= 1'b0;
      REGEN_SELECT_O    <= 8'h00;
      DISP_ALARM_O      <= 1'b0;
      DISP_WARN_O       <= 1'b0;
      DISP_CODE_O       <= 8'h00;
      DISP_ITEM_O       <= 3'h0;
    end else begin
      READY_O           <= ready;
      // RL13 trouble off on alarm
      TROUBLE_OUTPUT_O  <= ready && (next_alm_lat == 16'h0000);
      // RL3 contactor drive select
      CONTACTOR_DRIVE_O <= ready && (act_mcc[3:0] == 4'h1);
      // RL1 regen select out
      REGEN_SELECT_O    <= act_regen[7:0];
      DISP_ALARM_O      <= (next_alm_lat != 16'h0000);
      DISP_WARN_O       <= (warn_q != 5'h00);
      // RL13 show alarm number
      if (next_alm_lat != 16'h0000) begin
        DISP_CODE_O <= new_alarm ? first_code(alm_ev) : hist[0];
      end else begin
        DISP_CODE_O <= 8'h00;
        for (int i = cpa_pkg::NUM_WARN - 1; i >= 0; i--) begin
          if (warn_q[i]) begin
            DISP_CODE_O <= cpa_pkg::WARN_CODE[i];
          end
        end
      end
      // RL4 power-on display item
      DISP_ITEM_O <= (act_disp[7:0] <= cpa_pkg::DISP_ITEM_MAX) ? act_disp[2:0] : 3'h0;
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  assign irq_ev = {state == cpa_pkg::ST_ERASE, 1'b0, 1'b0, 1'b0} |
                  {1'b0, ready & ~READY_O, |(WARN_DETECT_I & ~warn_q & {5{ready}}), new_alarm};

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      irq_stat <= 4'h0;
    end else if (wb_wr && (ADR_I == cpa_pkg::ADR_IRQ_CLR) && SEL_I[0]) begin
      irq_stat <= (irq_stat & ~DAT_I[3:0]) | irq_ev;
    end else begin
      irq_stat <= irq_stat | irq_ev;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      irq_en <= 4'h0;
    end else if (wb_wr && (ADR_I == cpa_pkg::ADR_IRQ_EN) && SEL_I[0]) begin
      irq_en <= DAT_I[3:0];
    end
  end
  assign IRQ_O = |(irq_stat & irq_en);

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h00000000;
    if (p_hit) begin
      rd_data = {16'h0000, nv_param[p_idx]};
    end else if (h_hit) begin
      rd_data = {24'h000000, hist[h_idx]};
    end else begin
      unique case (ADR_I)
        cpa_pkg::ADR_ALM_STAT: rd_data = {alm_lat, 6'h00, ready, |alm_lat, hist[0]};
        cpa_pkg::ADR_WARN:     rd_data = {27'h0000000, warn_q};
        cpa_pkg::ADR_ACTIVE:   rd_data = {act_disp[3:0], act_filt[3:0], act_mcc[3:0], 4'h0, act_regen};
        cpa_pkg::ADR_WR_COUNT: rd_data = nv_wr_count;
        cpa_pkg::ADR_IRQ_STAT: rd_data = {28'h0000000, irq_stat};
        cpa_pkg::ADR_IRQ_EN:   rd_data = {28'h0000000, irq_en};
        default:               rd_data = 32'h00000000;
      endcase
    end
  end

  // one wait state: ack in the cycle after the request, dropped the next
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ACK_O <= 1'b0;
      DAT_O <= 32'h00000000;
    end else begin
      ACK_O <= wb_req;
      DAT_O <= wb_req ? rd_data : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  trouble_on_alarm_a: assert property (new_alarm |=> !TROUBLE_OUTPUT_O && DISP_ALARM_O) // RL13
    else $error("trouble output not dropped on alarm");
  alarm_held_a: assert property (alm_lat[cpa_pkg::ALM_PRM] |=> alm_lat[cpa_pkg::ALM_PRM]) // RL12
    else $error("nonresettable alarm was cleared");
  reset_clears_a: assert property (err_reset && alm_lat[0] && !alm_ev[0] |=> !alm_lat[0]) // RL11
    else $error("undervoltage not cleared by error reset");
  param_error_a: assert property (ready && !regen_ok |=> alm_lat[cpa_pkg::ALM_PRM]) // RL2
    else $error("bad regen option without parameter error");
  uv_delay_a: assert property ($rose(uv_ev) |-> $past(CTRL_POWER_OK_I) == 1'b0 && uv_cnt == 32'(UV_LIMIT) + 1) // RL14
    else $error("undervoltage raised at wrong time");
  erase_self_a: assert property (state == cpa_pkg::ST_ERASE |=> nv_param[cpa_pkg::IDX_ERASE] == 16'h0000 &&
                                 hist[0] == 8'h00) // RL6
    else $error("erase setting not cleared after history erase");
  load_first_a: assert property ($rose(ready) |-> $past(state == cpa_pkg::ST_LOAD, 1) ||
                                 $past(state == cpa_pkg::ST_ERASE, 1)) // RL19
    else $error("ready reached without loading settings");
  contactor_a: assert property (ready && act_mcc[3:0] == 4'h0 |=> !CONTACTOR_DRIVE_O) // RL3
    else $error("contactor drive on while deselected");
  hist_push_a: assert property (new_alarm |=> hist[1] == $past(hist[0])) // RL18
    else $error("history not shifted on new alarm");
  wr_limit_a: assert property (ready && nv_wr_count > 32'(WR_LIMIT) |=> alm_lat[cpa_pkg::ALM_NVM]) // RL15
    else $error("write limit passed without memory alarm");
  ack_pulse_a: assert property (ACK_O |=> !ACK_O)
    else $error("ack held more than one cycle");

  alarm_c: cover property (new_alarm ##[1:20] err_reset);
  erase_c: cover property (state == cpa_pkg::ST_ERASE);
  filter_c: cover property ($rose(FILT_IN_O[0]));
  irq_c: cover property ($rose(IRQ_O));
endmodule // cpa_unit
